/* include/rsc_pkg.sv */
// Shared constants and types for the remote status and control block
`default_nettype none
package rsc_pkg;

  // ------------------------------------------------------------
  // Clock and debounce timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned DEB_TIME_NS   = 10000;
  localparam int unsigned DEB_CYCLES    =
    (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W     = 12;
  localparam logic [DEB_CNT_W-1:0] DEB_LAST =
    DEB_CNT_W'(DEB_CYCLES - 1);

  // ------------------------------------------------------------
  // Contact inputs and reset levels
  // ------------------------------------------------------------
  localparam int unsigned NUM_IN      = 4;
  localparam int unsigned IN_MODE     = 0;
  localparam int unsigned IN_POINT    = 1;
  localparam int unsigned IN_RANGE    = 2;
  localparam int unsigned IN_SENSOR   = 3;
  localparam logic        CONTACT_RST = 1'b1;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_STATUS   = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;

  // Control register fields
  localparam int unsigned CTRL_REMOTE = 0;
  localparam int unsigned CTRL_CAL    = 1;
  localparam int unsigned CTRL_SPAN   = 2;
  localparam int unsigned CTRL_RANGE2 = 3;
  localparam int unsigned CTRL_CO2    = 4;
  localparam int unsigned CTRL_RMODE  = 5;
  localparam logic [7:0]  CTRL_RST    = 8'h21;

  // Status register field positions
  localparam int unsigned STAT_BITS  = 0;
  localparam int unsigned STAT_CONT  = 6;
  localparam int unsigned STAT_LABEL = 10;

  // Interrupt layout
  localparam int unsigned IRQ_W       = 6;
  localparam int unsigned IRQ_HEALTH  = 4;
  localparam int unsigned IRQ_INVALID = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RSC_RANGE_SINGLE = 3'b001,
    RSC_RANGE_DUAL   = 3'b010,
    RSC_RANGE_AUTO   = 3'b100
  } rsc_range_e;

  // Six status pins, bit 5 first
  typedef struct packed {
    logic co2_cal;
    logic high_range_status_bit;
    logic span_point;
    logic cal_mode;
    logic conc_valid;
    logic system_ok;
  } rsc_status_s;

  typedef struct packed {
    logic zero_mode;
    logic co2;
    logic cal;
    logic span;
    logic high_range;
  } rsc_label_s;

  typedef struct packed {
    logic co2;
    logic range2;
    logic span;
    logic cal;
  } rsc_select_s;

endpackage
`default_nettype wire

/* core/rsc_debounce.sv */
// Three-stage synchroniser and stability filter for one contact input
`default_nettype none
module rsc_debounce (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // Raw contact level, asynchronous
  input  wire logic pin_in,
  // Filtered level
  output logic      level_out
);

  logic                          s1_r;
  logic                          s2_r;
  logic                          s3_r;
  logic [rsc_pkg::DEB_CNT_W-1:0] cnt_r;
  logic                          agree;
  logic                          differs;

  // Only the second and third stages are compared
  assign agree   = (s2_r == s3_r);
  assign differs = agree && (s3_r != level_out);

  // Synchroniser chain
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      s1_r <= rsc_pkg::CONTACT_RST;
      s2_r <= rsc_pkg::CONTACT_RST;
      s3_r <= rsc_pkg::CONTACT_RST;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Any disagreement restarts the count, so bounce never gets through
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cnt_r     <= '0;
      level_out <= rsc_pkg::CONTACT_RST;
    end else if (!differs) begin
      cnt_r     <= '0;
    end else if (cnt_r == rsc_pkg::DEB_LAST) begin
      cnt_r     <= '0;
      level_out <= s3_r;
    end else begin
      cnt_r     <= cnt_r + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* core/rsc_io.sv */
// Status outputs and remote contact inputs with an Avalon-MM slave
//
// How it works
// - Health output on when no fault exists, off on any alarm.
// - Valid output on only for valid readings; off in hold-off or fault.
// - Calibration-mode output on in calibration, off in measure mode.
// - Point output on for upscale calibration, off for baseline.
// - Range output on in high range of dual or auto; off single.
// - Sensor output on while carbon dioxide calibrates, off for oxygen.
// - Mode contact open selects calibration, closed selects measure.
// - Point contact open selects upscale, closed selects baseline.
// - Range contact open selects range two, closed selects range one.
// - Sensor contact open selects oxygen, closed selects carbon dioxide.
// - Remote baseline shows zero-mode label; else gas, state and range.
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
module rsc_io (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  // Avalon-MM slave
  input  wire logic [4:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // Interrupt
  output logic                       irq_out,
  // Analyzer conditions, same clock
  input  wire logic                  fault_in,
  input  wire logic                  alarm_in,
  input  wire logic                  reading_ok_in,
  input  wire logic                  hold_off_in,
  input  wire logic                  auto_high_in,
  // Contact inputs, high means closed, asynchronous
  input  wire logic [3:0]            contact_closed_in,
  // Status pins, high means transistor on
  output rsc_pkg::rsc_status_s       status_out,
  // Front panel mode label
  output rsc_pkg::rsc_label_s        gas_cal_mode_label_out,
  // Selection handed to the measurement engine
  output rsc_pkg::rsc_select_s       select_out
);

  // ------------------------------------------------------------
  // Contact filtering
  // ------------------------------------------------------------
  logic [rsc_pkg::NUM_IN-1:0] closed;
  logic [rsc_pkg::NUM_IN-1:0] closed_prev_r;

  // One filter per contact
  genvar gi;
  generate
    for (gi = 0; gi < rsc_pkg::NUM_IN; gi++) begin : g_deb
      rsc_debounce u_deb (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     (contact_closed_in[gi]),
        .level_out  (closed[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic                    ack_r;
  logic                    req;
  logic                    wr_fire;
  logic                    rd_take;
  logic                    sel_ctrl;
  logic                    sel_status;
  logic                    sel_istat;
  logic                    sel_imask;
  logic                    lane0;
  logic [7:0]              ctrl_r;
  logic [rsc_pkg::IRQ_W-1:0] irq_stat_r;
  logic [rsc_pkg::IRQ_W-1:0] irq_mask_r;
  logic [rsc_pkg::IRQ_W-1:0] irq_set;
  logic [rsc_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]             rd_mux;
  logic [31:0]             status_word;

  // Every access waits exactly one cycle, the answer is then registered
  assign req        = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = req && !ack_r;
  assign wr_fire    = avs_write_in && ack_r;
  assign rd_take    = avs_read_in && !ack_r;
  assign lane0      = avs_byteenable_in[0];

  // Address decode
  assign sel_ctrl   = (avs_address_in == rsc_pkg::OFF_CTRL);
  assign sel_status = (avs_address_in == rsc_pkg::OFF_STATUS);
  assign sel_istat  = (avs_address_in == rsc_pkg::OFF_IRQ_STAT);
  assign sel_imask  = (avs_address_in == rsc_pkg::OFF_IRQ_MASK);

  // Handshake sequencing
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Control register; all fields live in byte lane 0
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl_r <= rsc_pkg::CTRL_RST;
    end else if (wr_fire && sel_ctrl && lane0) begin
      ctrl_r <= avs_writedata_in[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      irq_mask_r <= rsc_pkg::IRQ_MASK_RST;
    end else if (wr_fire && sel_imask && lane0) begin
      irq_mask_r <= avs_writedata_in[rsc_pkg::IRQ_W-1:0];
    end
  end

  // Write-one-to-clear, a new event in the same cycle wins
  assign irq_clr = (wr_fire && sel_istat && lane0) ?
                   avs_writedata_in[rsc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq_out = |(irq_stat_r & irq_mask_r);

  // ------------------------------------------------------------
  // Selection of the calibration state
  // ------------------------------------------------------------
  logic                remote;
  logic                sel_cal;
  logic                sel_span;
  logic                sel_range2;
  logic                sel_co2;
  rsc_pkg::rsc_range_e range_mode;
  logic                high_range;

  // Remote contacts govern unless software takes local control
  assign remote     = ctrl_r[rsc_pkg::CTRL_REMOTE];
  assign sel_cal    = remote ? !closed[rsc_pkg::IN_MODE] :
                      ctrl_r[rsc_pkg::CTRL_CAL];
  assign sel_span   = remote ? !closed[rsc_pkg::IN_POINT] :
                      ctrl_r[rsc_pkg::CTRL_SPAN];
  assign sel_range2 = remote ? !closed[rsc_pkg::IN_RANGE] :
                      ctrl_r[rsc_pkg::CTRL_RANGE2];
  assign sel_co2    = remote ? closed[rsc_pkg::IN_SENSOR] :
                      ctrl_r[rsc_pkg::CTRL_CO2];

  // Range configuration; an illegal code falls back to single range
  always_comb begin
    case (ctrl_r[rsc_pkg::CTRL_RMODE +: 3])
      3'h2:    range_mode = rsc_pkg::RSC_RANGE_DUAL;
      3'h4:    range_mode = rsc_pkg::RSC_RANGE_AUTO;
      default: range_mode = rsc_pkg::RSC_RANGE_SINGLE;
    endcase
  end

  // Dual range follows the range selection, auto range the analyzer
  always_comb begin
    case (range_mode)
      rsc_pkg::RSC_RANGE_DUAL: high_range = sel_range2;
      rsc_pkg::RSC_RANGE_AUTO: high_range = auto_high_in;
      default:                 high_range = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Status pins and mode label
  // ------------------------------------------------------------
  rsc_pkg::rsc_status_s status_nxt;
  rsc_pkg::rsc_label_s  label_nxt;
  rsc_pkg::rsc_select_s select_nxt;
  logic                 baseline_remote;

  // Calibration masks the valid output directly, so the reading is never valid then
  assign status_nxt.system_ok  = !fault_in && !alarm_in;
  assign status_nxt.conc_valid = reading_ok_in && !hold_off_in
                                 && !sel_cal && !fault_in;
  assign status_nxt.cal_mode   = sel_cal;
  assign status_nxt.span_point = sel_cal && sel_span;
  assign status_nxt.high_range_status_bit = high_range;
  assign status_nxt.co2_cal    = sel_cal && sel_co2;

  // Baseline calibration under remote control shows only zero mode
  assign baseline_remote     = remote && sel_cal && !sel_span;
  assign label_nxt.zero_mode  = baseline_remote;
  assign label_nxt.co2        = !baseline_remote && sel_co2;
  assign label_nxt.cal        = !baseline_remote && sel_cal;
  assign label_nxt.span       = !baseline_remote && sel_cal
                                && sel_span;
  assign label_nxt.high_range = !baseline_remote && high_range;

  // Selection for the measurement engine
  assign select_nxt.cal    = sel_cal;
  assign select_nxt.span   = sel_span;
  assign select_nxt.range2 = sel_range2;
  assign select_nxt.co2    = sel_co2;

  // Outputs are registered so the isolators never see decode glitches
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      status_out             <= '0;
      gas_cal_mode_label_out <= '0;
      select_out             <= '0;
    end else begin
      status_out             <= status_nxt;
      gas_cal_mode_label_out <= label_nxt;
      select_out             <= select_nxt;
    end
  end

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  // Previous filtered contact levels for change detection
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      closed_prev_r <= {rsc_pkg::NUM_IN{rsc_pkg::CONTACT_RST}};
    end else begin
      closed_prev_r <= closed;
    end
  end

  // A contact change, loss of health or loss of validity raises a flag
  assign irq_set[rsc_pkg::NUM_IN-1:0] = closed ^ closed_prev_r;
  assign irq_set[rsc_pkg::IRQ_HEALTH]  =
    status_out.system_ok && !status_nxt.system_ok;
  assign irq_set[rsc_pkg::IRQ_INVALID] =
    status_out.conc_valid && !status_nxt.conc_valid;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Status word packs pins, filtered contacts and label
  assign status_word = {17'h00000,
                        gas_cal_mode_label_out,
                        closed,
                        status_out};

  // Unmapped addresses read as zero
  assign rd_mux = sel_ctrl   ? {24'h000000, ctrl_r} :
                  sel_status ? status_word :
                  sel_istat  ? {26'h0000000, irq_stat_r} :
                  sel_imask  ? {26'h0000000, irq_mask_r} :
                  32'h00000000;

  // Captured in the wait cycle, stands when waitrequest drops
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (rd_take) begin
      avs_readdata_out <= rd_mux;
    end
  end

endmodule
`default_nettype wire

/* verification/rsc_plc_model.sv */
// Remote controller model that opens and closes the four contacts
`default_nettype none
module rsc_plc_model (
  // Clock
  input  wire logic       ref_clk_in,
  // Requested contact states, high means open
  input  wire logic [3:0] open_req_in,
  // Contact lines to the analyzer, high means closed
  output logic      [3:0] contact_closed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Contact drive
  // ------------------------------------------------------------
  // Starts closed, so the analyzer powers up in measure mode
  initial contact_closed_out = 4'hf;
  // Relay outputs move just after an edge, never mid-cycle
  always @(posedge ref_clk_in) begin
    contact_closed_out <= ~open_req_in;
  end
endmodule
`default_nettype wire

/* verification/rsc_io_monitor.sv */
// Concurrent checks on the ports of the remote status and control block
`default_nettype none
module rsc_io_monitor (
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  // Bus handshake
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic                  avs_waitrequest_out,
  // Conditions and contacts
  input  wire logic                  fault_in,
  input  wire logic                  alarm_in,
  input  wire logic                  reading_ok_in,
  input  wire logic                  hold_off_in,
  input  wire logic [3:0]            contact_closed_in,
  // Outputs under watch
  input  wire rsc_pkg::rsc_status_s  status_out,
  input  wire rsc_pkg::rsc_label_s   gas_cal_mode_label_out,
  input  wire rsc_pkg::rsc_select_s  select_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] stab_r;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Cycles the contact lines have held still; saturates to avoid wrap
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || $changed(contact_closed_in)) begin
      stab_r <= 12'h000;
    end else if (stab_r != 12'hfff) begin
      stab_r <= stab_r + 12'h001;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_health_follow: assert property ($past(rst_b_in) |->
    status_out.system_ok == $past(!fault_in && !alarm_in))
    else $error("health output does not follow fault and alarm");
  a_valid_cause: assert property (status_out.conc_valid |->
    $past(reading_ok_in && !hold_off_in && !fault_in) && !status_out.cal_mode)
    else $error("valid output set without a valid reading");
  a_cal_follow: assert property (
    status_out.cal_mode == select_out.cal)
    else $error("calibration output differs from selection");
  a_point_gate: assert property (
    status_out.span_point == (select_out.cal && select_out.span))
    else $error("point output differs from selection");
  a_gas_gate: assert property (
    status_out.co2_cal == (select_out.cal && select_out.co2))
    else $error("sensor output differs from selection");
  a_zero_label: assert property (gas_cal_mode_label_out.zero_mode |->
    gas_cal_mode_label_out[3:0] == 4'h0 && status_out.cal_mode
    && !select_out.span)
    else $error("zero label shown outside baseline calibration");
  a_range_label: assert property (!gas_cal_mode_label_out.zero_mode |->
    gas_cal_mode_label_out.high_range == status_out.high_range_status_bit)
    else $error("label range differs from range output");
  a_mode_debounce: assert property ($changed(select_out)
    && $past(rst_b_in, 2) && !$past(avs_write_in)
    && !$past(avs_write_in, 2) |-> stab_r >= rsc_pkg::DEB_LAST)
    else $error("selection moved before contacts settled");
  a_wait_one: assert property ((avs_read_in || avs_write_in) // bus
    && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait cycle");
  a_wait_idle: assert property (!avs_read_in && !avs_write_in |-> // bus
    !avs_waitrequest_out)
    else $error("wait request without a request");
endmodule
bind rsc_io rsc_io_monitor u_rsc_io_monitor (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .fault_in(fault_in), .alarm_in(alarm_in), .reading_ok_in(reading_ok_in),
  .hold_off_in(hold_off_in), .contact_closed_in(contact_closed_in),
  .status_out(status_out), .gas_cal_mode_label_out(gas_cal_mode_label_out),
  .select_out(select_out));
`default_nettype wire

/* verification/rsc_io_test.sv */
// Self-checking testbench for the remote status and control block
`default_nettype none
module rsc_io_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk_in;
  logic                 rst_b_in;
  logic                 rd;
  logic                 wr;
  logic [4:0]           adr;
  logic [31:0]          wd;
  logic [31:0]          rdat;
  logic [31:0]          q;
  logic                 wt;
  logic                 irq;
  logic                 fault;
  logic                 alarm;
  logic                 rok;
  logic                 hold;
  logic                 ahi;
  logic [3:0]           opn;
  logic [3:0]           closed;
  rsc_pkg::rsc_status_s st;
  rsc_pkg::rsc_label_s  lb;
  rsc_pkg::rsc_select_s sel;
  int                   error_cnt;
  int                   tests_run;
  // ------------------------------------------------------------
  // Design and remote controller
  // ------------------------------------------------------------
  rsc_io u_rsc_io (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .irq_out(irq), .fault_in(fault),
    .alarm_in(alarm), .reading_ok_in(rok), .hold_off_in(hold),
    .auto_high_in(ahi), .contact_closed_in(closed), .status_out(st),
    .gas_cal_mode_label_out(lb), .select_out(sel));
  rsc_plc_model u_rsc_plc_model (
    .ref_clk_in(ref_clk_in), .open_req_in(opn), .contact_closed_out(closed));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wt !== 1'b0 && n < 50);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // Let an idle edge pass so a following call never re-drives the strobe
    @(posedge ref_clk_in);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // Move contacts, wait for the filtered selection, then judge outputs
  task automatic t_sel(input logic [3:0] o, input logic [3:0] es,
                       input logic [4:0] et, input logic [4:0] el);
    int n;
    n = 0;
    opn <= o;
    while (sel !== es && n < 3000) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      give_verdict();
    end
    tick(2);
    chk(sel, es);
    chk(st[5:1], et);
    chk(lb, el);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    bus(1'b0, rsc_pkg::OFF_CTRL, 32'h0, q);
    chk(q, 32'h21);
    bus(1'b0, rsc_pkg::OFF_IRQ_MASK, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 5'h10, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_health();
    logic [1:0] fa;
    bus(1'b1, rsc_pkg::OFF_IRQ_MASK, 32'h10, q);
    for (int i = 0; i < 4; i++) begin
      fa = i[1:0];
      fault <= fa[1];
      alarm <= fa[0];
      tick(3);
      chk(st.system_ok, fa == 2'b00);
    end
    chk(irq, 1'b1);
    fault <= 1'b0;
    alarm <= 1'b0;
    bus(1'b1, rsc_pkg::OFF_IRQ_STAT, 32'h10, q);
    tick(2);
    chk(irq, 1'b0);
    // Masked event must leave the line low
    bus(1'b1, rsc_pkg::OFF_IRQ_MASK, 32'h0, q);
    alarm <= 1'b1;
    tick(3);
    chk(irq, 1'b0);
    alarm <= 1'b0;
  endtask
  task automatic t_valid();
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      rok <= v[2];
      hold <= v[1];
      fault <= v[0];
      tick(3);
      chk(st.conc_valid, v == 3'b100);
    end
    // Leave a valid reading behind for the measure-mode checks
    rok <= 1'b1;
    hold <= 1'b0;
    fault <= 1'b0;
  endtask
  // Short bounce on the mode contact must not reach any output
  task automatic t_glitch();
    opn <= 4'h1;
    tick(100);
    chk(sel, 4'h8);
    opn <= 4'h0;
    tick(2700);
    chk(sel, 4'h8);
    // No filtered contact change may have been flagged
    bus(1'b0, rsc_pkg::OFF_IRQ_STAT, 32'h0, q);
    chk(q[3:0], 4'h0);
  endtask
  // ------------------------------------------------------------
  // Clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {rst_b_in, rd, wr, fault, alarm, rok, hold, ahi} = 8'h00;
    adr = 5'h00;
    wd = 32'h0;
    opn = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    tick(5);
    rst_b_in <= 1'b1;
    tick(1);
    t_regs();
    t_health();
    t_valid();
    t_glitch();
    t_sel(4'h1, 4'h9, 5'h12, 5'h10);
    t_sel(4'h3, 4'hb, 5'h16, 5'h0e);
    t_sel(4'hb, 4'h3, 5'h06, 5'h06);
    bus(1'b1, rsc_pkg::OFF_CTRL, 32'h41, q);
    t_sel(4'hf, 4'h7, 5'h0e, 5'h07);
    bus(1'b1, rsc_pkg::OFF_CTRL, 32'h21, q);
    t_sel(4'hf, 4'h7, 5'h06, 5'h06);
    t_sel(4'h0, 4'h8, 5'h01, 5'h08);
    // Every contact has opened and closed again, so each change flag is set
    bus(1'b0, rsc_pkg::OFF_IRQ_STAT, 32'h0, q);
    chk(q[3:0], 4'hf);
    // Local control with auto range follows the analyzer's range flag
    ahi <= 1'b1;
    bus(1'b1, rsc_pkg::OFF_CTRL, 32'h9a, q);
    t_sel(4'h0, 4'hd, 5'h1a, 5'h0d);
    ahi <= 1'b0;
    t_sel(4'h0, 4'hd, 5'h12, 5'h0c);
    bus(1'b1, rsc_pkg::OFF_CTRL, 32'h21, q);
    bus(1'b0, rsc_pkg::OFF_STATUS, 32'h0, q);
    chk(q[9:6], 4'hf);
    give_verdict();
  end
endmodule
`default_nettype wire
